/* core/ckp_pkg.sv */
// Package with register map, field layout, constants and state types of the chroma keyer.
package ckp_pkg;

  // ==========================================================
  // Register byte offsets.
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_BGHUE = 8'h04;
  localparam logic [7:0] A_FGHUE = 8'h08;
  localparam logic [7:0] A_CORR = 8'h0C;
  localparam logic [7:0] A_CORE = 8'h10;
  localparam logic [7:0] A_MATTE = 8'h14;
  localparam logic [7:0] A_KEYVGC = 8'h18;
  localparam logic [7:0] A_SHADOW = 8'h1C;
  localparam logic [7:0] A_CURSOR = 8'h20;
  localparam logic [7:0] A_CAPT = 8'h24;
  localparam logic [7:0] A_STAT = 8'h28;

  // ==========================================================
  // Field positions: fields start at bit 0, 8, 16 or 24 of a word.
  localparam int F_B1 = 8;
  localparam int F_B2 = 16;
  localparam int F_B3 = 24;
  // Control register bits.
  localparam int B_FULLBW = 0;
  localparam int B_BGMASK = 1;
  localparam int B_FGMASK = 2;
  localparam int B_BGCORE = 3;
  localparam int B_VERT = 4;
  localparam int B_CURSOR = 5;

  // ==========================================================
  // Reset values and video levels.
  localparam logic [7:0] GAIN_RST = 8'h10;
  localparam logic [9:0] BLACK_Y = 10'h040;
  localparam logic [9:0] MID_C = 10'h200;
  localparam logic [9:0] CURSOR_Y = 10'h3AC;
  localparam logic [9:0] MOTION_LVL = 10'h040;
  localparam int LINE_LEN = 1024;

  // ==========================================================
  // Software settings.
  typedef struct packed {
    logic [5:0] ctrl;
    logic [7:0] bg_u, bg_v, fg_u, fg_v;
    logic [2:0] ap;
    logic [7:0] fringe, core_thr, matte_y, key_gain, sh_gain;
    logic [9:0] vcore, key_clip, sh_clip, cur_x, cur_y;
  } ckp_cfg_t;

  // State of the keyer apart from the line store, one register bank.
  typedef struct packed {
    ckp_cfg_t cfg;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic [9:0] px, ln;
    logic [7:0] uh, vh, up, vp;
    logic [7:0] u1, v1, bg2, fg2, bg3, fgd3, cap_u, cap_v, cap_cnt;
    logic [9:0] y1, y2, y3, y4, c1, c2, c3, c4, m1, m2, key4, keyp, cap_y;
    logic isv1, isv2, isv3, isv4, cur1, cur2, cur3, cur4, stb1;
    logic [9:0] ck_y, ck_c, ck_key;
    logic ck_isv;
  } ckp_state_t;

endpackage

/* core/ckp_keyer.sv */
// Chroma keyer datapath with APB settings and auto-setup capture.
//
// Functional notes
// RULE1 - Accept luma, 4:2:2 chroma, odd/even full-bandwidth chroma.
// RULE2 - Interpolate 4:2:2 chroma; select normal or full.
// RULE3 - Correlation grows as hue nears reference.
// RULE4 - Smaller aperture demands closer hue match.
// RULE5 - Fringe gives response in low-chroma areas.
// RULE6 - Foreground correlation never influences the key.
// RULE7 - Zero force mask stops suppression and key.
// RULE8 - Coring zeroes correlation not above threshold.
// RULE9 - Subtract correlation-shaped matte from input video.
// RULE10 - Key from background correlation via gain comparator.
// RULE11 - Separate force-mask switches for both paths.
// RULE12 - Foreground minus background avoids double suppression.
// RULE13 - Video coring to black only where key nonzero.
// RULE14 - Cursor inserted; strobe latches luma and chroma.
// RULE15 - Software reads captures per field, programs settings.
// RULE16 - Luma comparator shadow merged with key by max.
// RULE17 - Key filtered; vertical part bypassable.
// RULE18 - Output keyed luma, chroma and key.
// RULE19 - One clock; video and key delay-matched.
// RULE20 - Synchronous reset clears pipeline and captures.
`timescale 1ns/100ps
module ckp_keyer import ckp_pkg::*; (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [9:0] Y_IN,
  input wire logic [9:0] C_IN,
  input wire logic C_IS_V,
  input wire logic [9:0] FB_ODD,
  input wire logic [9:0] FB_EVEN,
  input wire logic [9:0] MASK_IN,
  input wire logic LINE_START,
  input wire logic FIELD_START,
  output logic [9:0] CK_Y,
  output logic [9:0] CK_C,
  output logic CK_C_IS_V,
  output logic [9:0] CK_KEY
);

  // ==========================================================
  // Helper functions.
  // Offset-binary 10-bit chroma to signed 8-bit.
  function automatic logic signed [7:0] c2s(input logic [9:0] c);
    c2s = $signed(c[9:2] ^ 8'h80);
  endfunction

  // Signed average of two chroma samples.
  function automatic logic [7:0] avg8(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {a[7], a} + {b[7], b};
    avg8 = s[8:1];
  endfunction

  // Hue correlation against a reference, with aperture and fringe.
  function automatic logic [7:0] corr_f(input logic [7:0] u, input logic [7:0] v,
    input logic [7:0] ru, input logic [7:0] rv, input logic [2:0] ap,
    input logic [7:0] fr);
    logic signed [17:0] dot, crs, r;
    logic [8:0] mag;
    dot = 18'($signed(u)) * 18'($signed(ru)) + 18'($signed(v)) * 18'($signed(rv));
    crs = 18'($signed(u)) * 18'($signed(rv)) - 18'($signed(v)) * 18'($signed(ru));
    if (crs < 0) begin
      crs = -crs;
    end
    // Off-axis error is divided by two to the power of the aperture, so a small one rejects more. RULE3 RULE4
    r = (dot - (crs >>> ap)) >>> 7;
    mag = 9'(u[7] ? -$signed(u) : $signed(u)) + 9'(v[7] ? -$signed(v) : $signed(v));
    // Weak chroma still answers when fringe is set. RULE5
    if ({1'b0, mag} < {2'b00, fr} && r < 18'($signed({10'h000, fr - mag[7:0]}))) begin
      r = 18'($signed({10'h000, fr - mag[7:0]}));
    end
    corr_f = (r < 0) ? 8'h00 : (r > 255) ? 8'hFF : r[7:0];
  endfunction

  // Clamp a signed value into the 10-bit video range.
  function automatic logic [9:0] clip10(input logic signed [12:0] x);
    clip10 = (x < 0) ? 10'h000 : (x > 1023) ? 10'h3FF : x[9:0];
  endfunction

  // Correlation-shaped matte component, signed.
  function automatic logic signed [12:0] shp(input logic [7:0] k, input logic [7:0] r);
    logic signed [17:0] p;
    p = 18'($signed({1'b0, k})) * 18'($signed(r));
    shp = 13'(p >>> 6);
  endfunction

  // Variable gain comparator: excess over clip times gain, clamped.
  function automatic logic [9:0] variable_gain_comparator(input logic signed [11:0] d, input logic [7:0] g);
    logic signed [20:0] p;
    p = (21'(d) * 21'($signed({1'b0, g}))) >>> 4;
    variable_gain_comparator = (p < 0) ? 10'h000 : (p > 1023) ? 10'h3FF : p[9:0];
  endfunction

  // Mapped address test, shared by error answer and write gating.
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= A_STAT);
  endfunction

  // ==========================================================
  // State and helper wires.
  ckp_state_t st; // Registered state.
  ckp_state_t nx; // Next state.
  logic [9:0] lmem [LINE_LEN]; // Previous line of the key, for vertical filtering.
  logic [9:0] lm_rd; // Key one line above.
  logic [9:0] kh_w; // Horizontally softened key.
  logic [9:0] kv_w; // Key after the vertical stage.
  logic [10:0] ks_w; // Sum used by the filters.
  logic [9:0] kd_w; // Line difference for motion detection.
  logic [9:0] yc_w; // Luma after video coring.
  logic [9:0] sh_w; // Shadow control.
  logic [9:0] kg_w; // Key from the comparator.
  logic [17:0] mp_w; // Force mask product.
  logic [8:0] fd_w; // Foreground difference.
  logic acc; // APB access phase completes now.

  assign lm_rd = lmem[st.px];

  // ==========================================================
  // Next-state logic for bus, pipeline and capture.
  always_comb begin
    nx = st;
    // APB: every transfer completes one cycle after setup.
    acc = PSEL & PENABLE & st.pready;
    nx.pready = PSEL & ~PENABLE;
    nx.pslverr = PSEL & ~PENABLE & ~mapped(PADDR);
    nx.prdata = 32'h0000_0000;
    if (PSEL & ~PENABLE & ~PWRITE) begin
      case (PADDR)
        A_CTRL: nx.prdata = {26'h0, st.cfg.ctrl};
        A_BGHUE: nx.prdata = {16'h0, st.cfg.bg_v, st.cfg.bg_u};
        A_FGHUE: nx.prdata = {16'h0, st.cfg.fg_v, st.cfg.fg_u};
        A_CORR: nx.prdata = {16'h0, st.cfg.fringe, 5'h0, st.cfg.ap};
        A_CORE: nx.prdata = {6'h0, st.cfg.vcore, 8'h0, st.cfg.core_thr};
        A_MATTE: nx.prdata = {24'h0, st.cfg.matte_y};
        A_KEYVGC: nx.prdata = {8'h0, st.cfg.key_gain, 6'h0, st.cfg.key_clip};
        A_SHADOW: nx.prdata = {8'h0, st.cfg.sh_gain, 6'h0, st.cfg.sh_clip};
        A_CURSOR: nx.prdata = {6'h0, st.cfg.cur_y, 6'h0, st.cfg.cur_x};
        // Capture words give software the sample under the cursor. RULE15
        A_CAPT: nx.prdata = {st.cap_v, st.cap_u, 6'h0, st.cap_y};
        A_STAT: nx.prdata = {24'h0, st.cap_cnt};
        default: nx.prdata = 32'h0000_0000;
      endcase
    end
    // Writes land only at the completing edge; unmapped writes are dropped.
    if (acc & PWRITE & ~st.pslverr) begin
      case (PADDR)
        A_CTRL: nx.cfg.ctrl = PWDATA[5:0];
        A_BGHUE: {nx.cfg.bg_v, nx.cfg.bg_u} = PWDATA[15:0];
        A_FGHUE: {nx.cfg.fg_v, nx.cfg.fg_u} = PWDATA[15:0];
        A_CORR: begin
          nx.cfg.ap = PWDATA[2:0];
          nx.cfg.fringe = PWDATA[F_B1 +: 8];
        end
        A_CORE: begin
          nx.cfg.core_thr = PWDATA[7:0];
          nx.cfg.vcore = PWDATA[F_B2 +: 10];
        end
        A_MATTE: nx.cfg.matte_y = PWDATA[7:0];
        A_KEYVGC: begin
          nx.cfg.key_clip = PWDATA[9:0];
          nx.cfg.key_gain = PWDATA[F_B2 +: 8];
        end
        A_SHADOW: begin
          nx.cfg.sh_clip = PWDATA[9:0];
          nx.cfg.sh_gain = PWDATA[F_B2 +: 8];
        end
        A_CURSOR: begin
          nx.cfg.cur_x = PWDATA[9:0];
          nx.cfg.cur_y = PWDATA[F_B2 +: 10];
        end
        default: nx.cfg = st.cfg;
      endcase
    end

    // Raster position from the line and field pulses.
    nx.px = LINE_START ? 10'h000 : st.px + 10'h001;
    nx.ln = FIELD_START ? 10'h000 : LINE_START ? st.ln + 10'h001 : st.ln;

    // Stage 1: hold the last two U and V of the 4:2:2 stream. RULE1
    if (C_IS_V) begin
      nx.vp = st.vh;
      nx.vh = c2s(C_IN);
    end else begin
      nx.up = st.uh;
      nx.uh = c2s(C_IN);
    end
    // Interpolated chroma unless full bandwidth is chosen. RULE1 RULE2
    nx.u1 = st.cfg.ctrl[B_FULLBW] ? c2s(FB_ODD) : avg8(st.up, st.uh);
    nx.v1 = st.cfg.ctrl[B_FULLBW] ? c2s(FB_EVEN) : avg8(st.vp, st.vh);
    nx.y1 = Y_IN;
    nx.c1 = C_IN;
    nx.isv1 = C_IS_V;
    nx.m1 = MASK_IN;
    nx.cur1 = st.cfg.ctrl[B_CURSOR] & ((st.px == st.cfg.cur_x) | (st.ln == st.cfg.cur_y));
    nx.stb1 = (st.px == st.cfg.cur_x) & (st.ln == st.cfg.cur_y);

    // Capture strobe latches the sample under the cursor. RULE14
    if (st.stb1) begin
      nx.cap_y = st.y1;
      nx.cap_u = st.u1;
      nx.cap_v = st.v1;
      nx.cap_cnt = st.cap_cnt + 8'h01;
    end

    // Stage 2: two correlators with their own reference hues. RULE3 RULE6
    nx.bg2 = corr_f(st.u1, st.v1, st.cfg.bg_u, st.cfg.bg_v, st.cfg.ap, st.cfg.fringe);
    nx.fg2 = corr_f(st.u1, st.v1, st.cfg.fg_u, st.cfg.fg_v, st.cfg.ap, st.cfg.fringe);
    {nx.y2, nx.c2, nx.isv2, nx.m2, nx.cur2} = {st.y1, st.c1, st.isv1, st.m1, st.cur1};

    // Stage 3: force mask on background, then coring. RULE7 RULE11
    mp_w = 18'(st.bg2) * 18'(st.m2);
    nx.bg3 = st.cfg.ctrl[B_BGMASK] ? mp_w[17:10] : st.bg2;
    if (st.cfg.ctrl[B_BGCORE] && nx.bg3 <= st.cfg.core_thr) begin
      nx.bg3 = 8'h00; // RULE8
    end
    // Foreground mask on its own switch, then the part left after background. RULE11 RULE12
    mp_w = 18'(st.fg2) * 18'(st.m2);
    fd_w = {1'b0, st.cfg.ctrl[B_FGMASK] ? mp_w[17:10] : st.fg2} - {1'b0, nx.bg3};
    nx.fgd3 = fd_w[8] ? 8'h00 : fd_w[7:0];
    {nx.y3, nx.c3, nx.isv3, nx.cur3} = {st.y2, st.c2, st.isv2, st.cur2};

    // Stage 4: suppress backing to black, foreground spill on chroma only. RULE9
    nx.y4 = clip10(13'($signed({3'b000, st.y3})) - shp(st.bg3, st.cfg.matte_y));
    nx.c4 = clip10(13'($signed({3'b000, st.c3}))
      - shp(st.bg3, st.isv3 ? st.cfg.bg_v : st.cfg.bg_u)
      - shp(st.fgd3, st.isv3 ? st.cfg.fg_v : st.cfg.fg_u));
    // Key only from background correlation, shadow from luma. RULE6 RULE10 RULE16
    kg_w = variable_gain_comparator($signed({2'b00, st.bg3, 2'b00}) - $signed({2'b00, st.cfg.key_clip}),
      st.cfg.key_gain);
    sh_w = variable_gain_comparator($signed({2'b00, st.cfg.sh_clip}) - $signed({2'b00, st.y3}), st.cfg.sh_gain);
    // Non-additive mix keeps the larger control. RULE16
    nx.key4 = (kg_w > sh_w) ? kg_w : sh_w;
    {nx.isv4, nx.cur4} = {st.isv3, st.cur3};

    // Stage 5: horizontal softening against the previous pixel. RULE17
    ks_w = {1'b0, st.key4} + {1'b0, st.keyp};
    kh_w = ks_w[10:1];
    nx.keyp = st.key4;
    // Vertical average, skipped where lines differ (motion) or when off. RULE17
    kd_w = (kh_w > lm_rd) ? kh_w - lm_rd : lm_rd - kh_w;
    ks_w = {1'b0, kh_w} + {1'b0, lm_rd};
    kv_w = (st.cfg.ctrl[B_VERT] && kd_w < MOTION_LVL) ? ks_w[10:1] : kh_w;
    // Video coring only inside a nonzero key. RULE13
    yc_w = (kv_w != 10'h000 && st.y4 < st.cfg.vcore) ? BLACK_Y : st.y4;
    // All three outputs leave on the same edge, pixel aligned. RULE18 RULE19
    nx.ck_y = st.cur4 ? CURSOR_Y : yc_w;
    nx.ck_c = st.cur4 ? MID_C : st.c4;
    nx.ck_isv = st.isv4;
    nx.ck_key = kv_w;
  end

  // ==========================================================
  // State register; reset clears pipeline, captures and horizontal filter, not the line store. RULE20
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      st <= '0;
      st.cfg.key_gain <= GAIN_RST;
      st.cfg.sh_gain <= GAIN_RST;
    end else begin
      st <= nx;
    end
  end

  // Line store is written every pixel, so switching vertical processing on averages against
  // the previous line, except in the first line after reset, which can read stale or never-written entries.
  always_ff @(posedge CLK) begin
    lmem[st.px] <= kh_w;
  end

  assign PRDATA = st.prdata;
  assign PREADY = st.pready;
  assign PSLVERR = st.pslverr;
  assign CK_Y = st.ck_y;
  assign CK_C = st.ck_c;
  assign CK_C_IS_V = st.ck_isv;
  assign CK_KEY = st.ck_key;

  // ==========================================================
  // Assertions and covers.
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  AST_RST_KEY: assert property ($rose(RESET_N) |-> CK_KEY == 10'h000) // RULE20
    else $error("key not zero after reset");
  AST_FULLBW: assert property (st.cfg.ctrl[B_FULLBW] |=> st.u1 == c2s($past(FB_ODD))) // RULE2
    else $error("full bandwidth select wrong");
  AST_MASK: assert property (st.cfg.ctrl[B_BGMASK] && st.m2 == 10'h000 |=> st.bg3 == 8'h00) // RULE7
    else $error("zero mask did not stop correlation");
  AST_CORE: assert property (st.cfg.ctrl[B_BGCORE] && !st.cfg.ctrl[B_BGMASK]
    && st.bg2 <= st.cfg.core_thr |=> st.bg3 == 8'h00) // RULE8
    else $error("coring let low level through");
  AST_FGDIFF: assert property (!st.cfg.ctrl[B_FGMASK] |=> st.fgd3 <= $past(st.fg2)) // RULE12
    else $error("foreground difference too large");
  AST_KEYZERO: assert property (st.bg3 == 8'h00 && sh_w == 10'h000
    |=> st.key4 == 10'h000 ##2 ($past(st.cfg.ctrl[B_VERT]) || CK_KEY <= $past(st.key4))) // RULE10
    else $error("key without background correlation");
  AST_VCORE: assert property (st.cur4 == 1'b0 && kv_w == 10'h000 |=> CK_Y == $past(st.y4)) // RULE13
    else $error("video cored outside key");
  AST_CAPTURE: assert property (st.stb1 |=> st.cap_y == $past(st.y1)
    && st.cap_cnt == $past(st.cap_cnt) + 8'h01) // RULE14
    else $error("capture did not latch");
  AST_HBYPASS: assert property (!st.cfg.ctrl[B_VERT] |=> CK_KEY == $past(kh_w)) // RULE17
    else $error("vertical bypass broken");

  COV_CAPTURE: cover property (st.stb1 ##1 st.cap_cnt != 8'h00);
  COV_FULLKEY: cover property (CK_KEY == 10'h3FF);
  COV_CORED: cover property (CK_KEY != 10'h000 && CK_Y == BLACK_Y);
  COV_VERT: cover property (st.cfg.ctrl[B_VERT] && kd_w < MOTION_LVL && kh_w != 10'h000);

endmodule

/* dv/ckp_xpt_model.sv */
// Crosspoint-side model: sources luma, chroma, mask and line and field pulses to the keyer.
`timescale 1ns/100ps
module ckp_xpt_model import ckp_pkg::*; #(
  parameter int PIX_PER_LINE = 32,
  parameter int LINES_PER_FIELD = 8
) (
  input wire logic clk,
  input wire logic [9:0] y_lvl,
  input wire logic [9:0] u_lvl,
  input wire logic [9:0] v_lvl,
  input wire logic [9:0] mask_lvl,
  output logic [9:0] y_out,
  output logic [9:0] c_out,
  output logic c_is_v,
  output logic [9:0] fb_odd,
  output logic [9:0] fb_even,
  output logic [9:0] mask_out,
  output logic line_start,
  output logic field_start
);
  // Short lines keep a field to a few hundred clocks, so capture tests stay quick.
  int px = 0;
  int ln = 0;

  // ==========================================================
  // Start-up levels: neutral chroma and black so nothing floats at time zero.
  initial begin
    y_out = BLACK_Y;
    c_out = MID_C;
    c_is_v = 1'b0;
    fb_odd = MID_C;
    fb_even = MID_C;
    mask_out = 10'h000;
    line_start = 1'b0;
    field_start = 1'b0;
  end

  // ==========================================================
  // Raster timing and bus sourcing, all changed just after the rising edge.
  always @(posedge clk) begin
    px <= (px == PIX_PER_LINE - 1) ? 0 : px + 1;
    if (px == PIX_PER_LINE - 1) begin
      ln <= (ln == LINES_PER_FIELD - 1) ? 0 : ln + 1;
    end
    line_start <= (px == PIX_PER_LINE - 1);
    field_start <= (px == PIX_PER_LINE - 1) && (ln == LINES_PER_FIELD - 1);
    // The multiplexed 4:2:2 bus alternates U and V samples with its phase flag.
    c_is_v <= ~c_is_v;
    c_out <= c_is_v ? u_lvl : v_lvl;
    y_out <= y_lvl;
    fb_odd <= u_lvl;
    fb_even <= v_lvl;
    mask_out <= mask_lvl;
  end
endmodule

/* dv/tb_chroma_keyer_pipeline.sv */
// Self-checking bench for the chroma keyer: settings bus, keying cases, capture and reset.
`timescale 1ns/100ps
module tb_chroma_keyer_pipeline import ckp_pkg::*;;
  // ==========================================================
  // Bench signals; every design input has a value at time zero.
  typedef struct packed {
    logic [31:0] ctrl, bg, fg, corr, core, shd;
    logic [9:0] y, u, v, mask, ey, ek;
    logic nz;
  } ckp_row_t;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [9:0] y_lvl = 10'h180;
  logic [9:0] u_lvl = 10'h200;
  logic [9:0] v_lvl = 10'h200;
  logic [9:0] mask_lvl = 10'h3FF;
  logic [31:0] prdata, r, s0;
  logic pready, pslverr, e, c_is_v, ck_c_is_v, line_start, field_start;
  logic [9:0] y_in, c_in, fb_odd, fb_even, mask_in, ck_y, ck_c, ck_key, k0, k7;
  int errors = 0;
  int checked = 0;
  int n_cur = 0;
  int n_v = 0;
  ckp_row_t rows [9];

  always #20 clk = ~clk;

  ckp_xpt_model xpt (.clk(clk), .y_lvl(y_lvl), .u_lvl(u_lvl), .v_lvl(v_lvl),
    .mask_lvl(mask_lvl), .y_out(y_in), .c_out(c_in), .c_is_v(c_is_v), .fb_odd(fb_odd),
    .fb_even(fb_even), .mask_out(mask_in), .line_start(line_start),
    .field_start(field_start));

  ckp_keyer dut (.CLK(clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .Y_IN(y_in), .C_IN(c_in), .C_IS_V(c_is_v), .FB_ODD(fb_odd),
    .FB_EVEN(fb_even), .MASK_IN(mask_in), .LINE_START(line_start),
    .FIELD_START(field_start), .CK_Y(ck_y), .CK_C(ck_c), .CK_C_IS_V(ck_c_is_v),
    .CK_KEY(ck_key));

  // ==========================================================
  // One APB transfer; the request stands until PREADY is seen high at an edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      errors++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, r, e);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // The stream answers in five edges; twelve leaves room for the softening stage.
  task automatic settle;
    repeat (12) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic final_report;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Watchdog: the whole sequence needs well under five thousand clocks.
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    final_report();
  end

  // ==========================================================
  // Main sequence.
  initial begin
    // ctrl, bg hue, fg hue, corr, core, shadow, y, u, v, mask, exp y, exp key, key nonzero.
    rows[0] = '{32'h6, 0, 0, 0, 0, 0, 10'h180, 10'h200, 10'h200, 10'h3FF, 10'h180, 0, 0};
    rows[1] = '{32'h6, 32'hF070, 0, 0, 0, 0, 10'h180, 10'h380, 10'h1C0, 0, 10'h180, 0, 0};
    rows[2] = '{32'hC, 32'hF070, 0, 0, 32'hFF, 0, 10'h180, 10'h380, 10'h1C0, 10'h3FF,
                10'h180, 0, 0};
    rows[3] = '{32'h6, 0, 32'hF070, 0, 0, 0, 10'h180, 10'h380, 10'h1C0, 10'h3FF, 10'h180,
                0, 0};
    rows[4] = '{32'h6, 0, 0, 0, 0, 32'h1003FF, 10'h100, 10'h200, 10'h200, 10'h3FF, 10'h100,
                10'h2FF, 0};
    rows[5] = '{32'h6, 32'hF070, 0, 32'h7, 32'h3FF0000, 0, 10'h180, 10'h380, 10'h1C0,
                10'h3FF, 10'h040, 0, 1};
    rows[6] = rows[5];
    rows[6].ctrl = 32'h7;
    rows[7] = '{32'h6, 0, 0, 32'h4000, 0, 0, 10'h180, 10'h200, 10'h200, 10'h3FF, 10'h180,
                10'h0FC, 0};
    rows[8] = '{32'h4, 32'hF070, 0, 32'h7, 0, 0, 10'h180, 10'h380, 10'h1C0, 0, 10'h180,
                0, 1};
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    // Reset values, then refused addresses that must leave settings alone.
    apb(1'b0, A_KEYVGC, 0, r, e);
    chk(r, 32'h00100000);
    apb(1'b0, A_SHADOW, 0, r, e);
    chk(r, 32'h00100000);
    apb(1'b1, 8'h2C, 32'hFFFFFFFF, r, e);
    chk(32'(e), 1);
    apb(1'b0, 8'h02, 0, r, e);
    chk(32'(e), 1);
    chk(r, 0);
    apb(1'b0, A_CTRL, 0, r, e);
    chk(r, 0);
    // Ordinary keying cases from the table.
    for (int i = 0; i < 9; i++) begin
      wr(A_CTRL, rows[i].ctrl);
      wr(A_BGHUE, rows[i].bg);
      wr(A_FGHUE, rows[i].fg);
      wr(A_CORR, rows[i].corr);
      wr(A_CORE, rows[i].core);
      wr(A_SHADOW, rows[i].shd | 32'h00100000);
      y_lvl <= rows[i].y;
      u_lvl <= rows[i].u;
      v_lvl <= rows[i].v;
      mask_lvl <= rows[i].mask;
      settle();
      chk(32'(ck_y), 32'(rows[i].ey));
      if (rows[i].nz) begin
        chk(32'(ck_key != 10'h000), 1);
      end else begin
        chk(32'(ck_key), 32'(rows[i].ek));
      end
    end
    // Off-axis hue with tight and wide aperture, then the matched hue.
    wr(A_CTRL, 32'h6);
    wr(A_CORE, 0);
    mask_lvl <= 10'h3FF;
    u_lvl <= 10'h380;
    v_lvl <= 10'h300;
    wr(A_CORR, 0);
    settle();
    k0 = ck_key;
    wr(A_CORR, 32'h7);
    settle();
    k7 = ck_key;
    @(posedge clk);
    v_lvl <= 10'h1C0;
    settle();
    chk(32'(k0 < k7), 1);
    chk(32'(k7 < ck_key), 1);
    // A still picture keeps its key level through the vertical stage.
    k0 = ck_key;
    wr(A_CTRL, 32'h16);
    repeat (4) settle();
    chk(32'(ck_key), 32'(k0));
    // Cursor capture: exactly three strobes in three field times.
    wr(A_CURSOR, 32'h00020005);
    wr(A_CTRL, 32'h26);
    y_lvl <= 10'h155;
    repeat (600) @(posedge clk);
    apb(1'b0, A_STAT, 0, s0, e);
    // In one field the cursor covers its whole row plus one pixel on the other seven lines.
    for (int i = 0; i < 765; i++) begin
      @(posedge clk);
      @(negedge clk);
      if (i < 256) begin
        n_cur += int'(ck_y == CURSOR_Y && ck_c == MID_C);
        n_v += int'(ck_c_is_v === 1'b1);
      end
    end
    apb(1'b0, A_STAT, 0, r, e);
    chk(32'(8'(r[7:0] - s0[7:0])), 3);
    chk(32'(n_cur), 39);
    chk(32'(n_v), 128);
    apb(1'b0, A_CAPT, 0, r, e);
    chk(32'(r[9:0]), 32'h155);
    // Reset in mid-run with a key present clears outputs and settings.
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(32'(ck_key), 0);
    chk(32'(ck_y), 0);
    @(posedge clk);
    reset_n <= 1'b1;
    apb(1'b0, A_STAT, 0, r, e);
    chk(32'(r < 2), 1);
    apb(1'b0, A_CTRL, 0, r, e);
    chk(r, 0);
    final_report();
  end
endmodule
